// File: logic/port4_storm_regs.svh
// register offsets, field positions, reset values and timing figures for the port-4 bank
`ifndef PORT4_STORM_REGS_SVH
`define PORT4_STORM_REGS_SVH

// register offsets on the management register port
`define CTRL4_OFS      8'h06
`define CTRL5_OFS      8'h07
`define TEST_A_OFS     8'h08
`define TEST_B_OFS     8'h09

// field positions inside the link-and-storm-high register
`define FLOW_BIT       5
`define SPEED_BIT      4
`define NULLVID_BIT    3
`define THR_HI_MSB     2

// reset and fixed read values
`define THR_HI_RST     3'h0
`define THR_LO_RST     8'h4a
`define TEST_A_VAL     8'h00
`define TEST_B_VAL     8'h4c

// storm measurement periods and core clock rate
`define PERIOD_100_MS  50
`define PERIOD_10_MS   500
`define CORE_CLK_KHZ   25000

// number of input ports metered
`define NUM_PORTS      4

`endif

// File: logic/port4_storm_pkg.sv
// shared types for the port-4 link and storm control bank
package port4_storm_pkg;
   typedef logic [7:0]  reg_byte_t;    // one management register
   typedef logic [10:0] storm_thr_t;   // storm threshold in 64-byte blocks
   typedef logic [23:0] period_cnt_t;  // measurement period timer
endpackage : port4_storm_pkg

// File: logic/storm_meter.sv
// per-port broadcast block counter with threshold compare
`timescale 1ns/1ps
module storm_meter (
   input  wire logic                      core_clk,
   input  wire logic                      rst_n,
   input  wire logic                      period_tick,
   input  wire logic                      block_in,
   input  wire port4_storm_pkg::storm_thr_t threshold,
   output logic                           blocked_r
);
   port4_storm_pkg::storm_thr_t count_r;    // blocks seen this period
   port4_storm_pkg::storm_thr_t count_nxt;
   logic                        blocked_nxt;

   // count saturates at the threshold, period start restarts it
   always_comb begin
      count_nxt   = count_r;
      blocked_nxt = blocked_r;
      if (period_tick) begin
         // a block landing on the tick is dropped; one block per period is noise
         count_nxt   = '0;
         blocked_nxt = 1'b0;
      end else begin
         if (block_in && (count_r < threshold)) begin
            count_nxt = count_r + 11'h001;
         end
         blocked_nxt = (count_nxt >= threshold);
      end
   end

   // register the meter
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r   <= '0;
         blocked_r <= 1'b0;
      end else begin
         count_r   <= count_nxt;
         blocked_r <= blocked_nxt;
      end
   end
endmodule : storm_meter

// File: logic/port4_link_and_storm_control_regs.sv
// port-4 link settings and broadcast storm control register bank
`timescale 1ns/1ps
`include "port4_storm_regs.svh"
module port4_link_and_storm_control_regs #(
   parameter int PERIOD_100_CYC = `PERIOD_100_MS * `CORE_CLK_KHZ,
   parameter int PERIOD_10_CYC  = `PERIOD_10_MS * `CORE_CLK_KHZ
) (
   input  wire logic                         core_clk,
   input  wire logic                         rstn,
   input  wire logic                         flow_control_strap_pin,
   input  wire logic                         speed_strap_pin,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   input  wire logic [7:0]                   reg_addr,
   input  wire logic [7:0]                   reg_wdata,
   output port4_storm_pkg::reg_byte_t        reg_rdata,
   output logic                              flow_ctrl_en,
   output logic                              speed_10m,
   output logic                              null_vid_replace,
   output port4_storm_pkg::storm_thr_t       storm_threshold,
   output logic                              period_tick,
   input  wire logic [`NUM_PORTS-1:0]        bcast_block_in,
   output logic      [`NUM_PORTS-1:0]        bcast_blocked
);
   // reset release synchroniser
   logic rst_meta_r;                          // first stage, read only by the second
   logic rst_n;                               // released reset for the bank

   // register state
   logic                        strap_done_r;       // straps captured after release
   logic                        strap_done_nxt;
   logic                        flow_nxt;
   logic                        speed_nxt;
   logic                        nullvid_nxt;
   logic [2:0]                  thr_hi_r;           // threshold bits 10..8
   logic [2:0]                  thr_hi_nxt;
   port4_storm_pkg::reg_byte_t  thr_lo_r;           // threshold bits 7..0
   port4_storm_pkg::reg_byte_t  thr_lo_nxt;
   port4_storm_pkg::reg_byte_t  rdata_nxt;

   // period timer state
   port4_storm_pkg::period_cnt_t timer_r;           // cycles into current period
   port4_storm_pkg::period_cnt_t timer_nxt;
   port4_storm_pkg::period_cnt_t period_last;       // last count of the period
   logic                         tick_nxt;

   // async assert, two-flop release; flops only take constants under reset
   // every flop in the bank leaves reset on one edge, whatever the pin's timing
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   // threshold is the two fields side by side, straight from flops
   // a write to one half takes effect alone; the meters may see a mixed value
   assign storm_threshold = {thr_hi_r, thr_lo_r};

   // register next values: strap capture, writes, reads
   // straps are read one edge after release, never under reset: a pin still
   // settling while reset is held cannot leak into the bank
   always_comb begin
      strap_done_nxt = 1'b1;
      flow_nxt       = flow_ctrl_en;
      speed_nxt      = speed_10m;
      nullvid_nxt    = null_vid_replace;
      thr_hi_nxt     = thr_hi_r;
      thr_lo_nxt     = thr_lo_r;
      rdata_nxt      = reg_rdata;
      if (!strap_done_r) begin
         // first cycle after release: pins hold their straps now
         flow_nxt  = flow_control_strap_pin;
         speed_nxt = speed_strap_pin;
      end else if (reg_wr) begin
         // writes to read-only or unmapped offsets are dropped
         // bits 7..6 of the control register live elsewhere; writes to them vanish
         if (reg_addr == `CTRL4_OFS) begin
            flow_nxt    = reg_wdata[`FLOW_BIT];
            speed_nxt   = reg_wdata[`SPEED_BIT];
            nullvid_nxt = reg_wdata[`NULLVID_BIT];
            thr_hi_nxt  = reg_wdata[`THR_HI_MSB:0];
         end else if (reg_addr == `CTRL5_OFS) begin
            thr_lo_nxt  = reg_wdata;
         end
      end
      if (reg_rd) begin
         // unmapped offsets and bits not held here read as zero
         unique case (reg_addr)
            `CTRL4_OFS: begin
               rdata_nxt = {2'b00, flow_ctrl_en, speed_10m, null_vid_replace, thr_hi_r};
            end
            `CTRL5_OFS:  rdata_nxt = thr_lo_r;
            `TEST_A_OFS: rdata_nxt = `TEST_A_VAL;
            `TEST_B_OFS: rdata_nxt = `TEST_B_VAL;
            default:     rdata_nxt = 8'h00;
         endcase
      end
   end

   // register bank flops; straps are not sampled under reset
   // threshold and null vid flops take their reset value here, flow and speed bits wait for the straps
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_done_r     <= 1'b0;
         flow_ctrl_en     <= 1'b0;
         speed_10m        <= 1'b0;
         null_vid_replace <= 1'b0;
         thr_hi_r         <= `THR_HI_RST;
         thr_lo_r         <= `THR_LO_RST;
         reg_rdata        <= 8'h00;
      end else begin
         strap_done_r     <= strap_done_nxt;
         flow_ctrl_en     <= flow_nxt;
         speed_10m        <= speed_nxt;
         null_vid_replace <= nullvid_nxt;
         thr_hi_r         <= thr_hi_nxt;
         thr_lo_r         <= thr_lo_nxt;
         reg_rdata        <= rdata_nxt;
      end
   end

   // period length follows the current speed setting
   // one timer serves every port, so all meters share the same period edges
   assign period_last = speed_10m ? 24'(PERIOD_10_CYC - 1)
                                  : 24'(PERIOD_100_CYC - 1);

   // period timer; a speed change mid-period wraps at once if already past
   // otherwise the running period just stretches or shrinks to the new length
   always_comb begin
      tick_nxt  = 1'b0;
      timer_nxt = timer_r + 24'h00_0001;
      if (timer_r >= period_last) begin
         timer_nxt = '0;
         tick_nxt  = 1'b1;
      end
   end

   // timer flops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_r     <= '0;
         period_tick <= 1'b0;
      end else begin
         timer_r     <= timer_nxt;
         period_tick <= tick_nxt;
      end
   end

   // one meter per input port, restarted by the period tick
   // meters share one threshold and one tick; only the block pulses differ
   for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_meter
      storm_meter u_meter (
         .core_clk    (core_clk),
         .rst_n       (rst_n),
         .period_tick (period_tick),
         .block_in    (bcast_block_in[p]),
         .threshold   (storm_threshold),
         .blocked_r   (bcast_blocked[p])
      );
      // once blocked, a port stays so until the tick; a raised threshold may free it early
      blocked_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
         (bcast_blocked[p] && !period_tick && $stable(storm_threshold))
         |=> bcast_blocked[p])
         else $error("port freed before period start");
   end

   // checks on the bank
   // all checks sleep under the released reset, so a mid-run reset starts them afresh
   // last timer count of each period, kept apart from the expression the timer uses
   localparam port4_storm_pkg::period_cnt_t PERIOD_100_LAST = 24'(PERIOD_100_CYC - 1);
   localparam port4_storm_pkg::period_cnt_t PERIOD_10_LAST  = 24'(PERIOD_10_CYC - 1);

   // a written flow bit shows on the pin one cycle later
   // writes before strap capture are refused, hence the capture guard
   flow_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (strap_done_r && reg_wr && reg_addr == `CTRL4_OFS)
      |=> (flow_ctrl_en == $past(reg_wdata[`FLOW_BIT])))
      else $error("flow control bit did not follow write");

   // strap level lands in the flow bit right after capture
   strap_flow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(strap_done_r) |-> (flow_ctrl_en == $past(flow_control_strap_pin)))
      else $error("flow control not loaded from strap");

   // a written speed bit shows one cycle later
   speed_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (strap_done_r && reg_wr && reg_addr == `CTRL4_OFS)
      |=> (speed_10m == $past(reg_wdata[`SPEED_BIT])))
      else $error("speed bit did not follow write");

   // strap level lands in the speed bit right after capture
   strap_speed_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(strap_done_r) |-> (speed_10m == $past(speed_strap_pin)))
      else $error("speed not loaded from strap");

   // null vid bit follows a write
   null_vid_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (strap_done_r && reg_wr && reg_addr == `CTRL4_OFS)
      |=> (null_vid_replace == $past(reg_wdata[`NULLVID_BIT])))
      else $error("null vid bit did not follow write");

   // control register reads back every field it holds
   // a write in the same cycle is not yet visible, so the old values come back
   ctrl4_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `CTRL4_OFS)
      |=> (reg_rdata[`NULLVID_BIT] == $past(null_vid_replace))
          && (reg_rdata[`FLOW_BIT] == $past(flow_ctrl_en))
          && (reg_rdata[`SPEED_BIT] == $past(speed_10m))
          && (reg_rdata[`THR_HI_MSB:0] == $past(thr_hi_r))
          && (reg_rdata[7:6] == 2'b00))
      else $error("control register readback wrong");

   // after capture, link bits move only on a control register write
   // so a strap level sticks until software overrides it
   cfg_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (strap_done_r && !(reg_wr && reg_addr == `CTRL4_OFS))
      |=> $stable(flow_ctrl_en) && $stable(speed_10m) && $stable(null_vid_replace))
      else $error("link bit changed without a write");

   // low byte write lands without touching the high bits
   thr_join_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (reg_wr && strap_done_r && reg_addr == `CTRL5_OFS)
      |=> (storm_threshold[7:0] == $past(reg_wdata))
          && (storm_threshold[10:8] == $past(thr_hi_r)))
      else $error("low threshold byte write wrong");

   // high bits write lands without touching the low byte
   hi_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (reg_wr && strap_done_r && reg_addr == `CTRL4_OFS)
      |=> (storm_threshold[10:8] == $past(reg_wdata[`THR_HI_MSB:0]))
          && (storm_threshold[7:0] == $past(thr_lo_r)))
      else $error("high threshold bits write wrong");

   // threshold moves only when one of its two registers is written
   // read-only and unmapped offsets must leave it alone
   thr_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (strap_done_r && !(reg_wr && (reg_addr == `CTRL4_OFS || reg_addr == `CTRL5_OFS)))
      |=> $stable(storm_threshold))
      else $error("threshold changed without a write");

   // low byte reads back as held
   lo_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `CTRL5_OFS) |=> (reg_rdata == $past(thr_lo_r)))
      else $error("low threshold byte readback wrong");

   // period timer at 100M: the tick follows the last count, then the timer restarts
   // two cycles of steady speed skip the early wrap that a speed change forces
   period_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (period_tick && !speed_10m && !$past(speed_10m) && !$past(speed_10m, 2))
      |-> (timer_r == 24'h00_0000) && ($past(timer_r) == PERIOD_100_LAST))
      else $error("100M period length wrong");

   // same at 10M, with the same two-cycle guard
   period_10_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (period_tick && speed_10m && $past(speed_10m) && $past(speed_10m, 2))
      |-> (timer_r == 24'h00_0000) && ($past(timer_r) == PERIOD_10_LAST))
      else $error("10M period length wrong");

   // the tick is a single-cycle pulse, so a meter restarts once per period
   tick_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      period_tick |=> !period_tick)
      else $error("period tick wider than one cycle");

   // threshold reset value, seen right after capture
   thr_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(strap_done_r) |-> (storm_threshold == 11'h04a))
      else $error("storm threshold reset value wrong");

   // period start frees port 0 if it is blocked
   storm_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (period_tick && storm_threshold != 11'h000) |=> !bcast_blocked[0])
      else $error("port still blocked after period start");

   // read data hold between reads; software may sample them late
   rdata_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   // fixed factory values read back
   test_a_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `TEST_A_OFS) |=> (reg_rdata == 8'h00))
      else $error("factory test a readback wrong");

   test_b_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `TEST_B_OFS) |=> (reg_rdata == 8'h4c))
      else $error("factory test b readback wrong");

endmodule : port4_link_and_storm_control_regs

// File: sim/mgmt_host.sv
// management host model driving the register strobe port
`timescale 1ns/1ps
module mgmt_host (
   input  wire logic                       core_clk,
   output logic                            reg_wr,
   output logic                            reg_rd,
   output logic [7:0]                      reg_addr,
   output logic [7:0]                      reg_wdata,
   input  wire port4_storm_pkg::reg_byte_t reg_rdata
);
   // idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // one-cycle write; bus scrambled after release so stale values never help
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk) #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge core_clk) #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr

   // one-cycle read, data taken once the strobe edge has landed
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk) #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge core_clk) #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask : rd
endmodule : mgmt_host

// File: sim/port4_link_and_storm_control_regs_tb_top.sv
// self-checking bench for the port-4 link and storm register bank
`timescale 1ns/1ps
`include "port4_storm_regs.svh"
module port4_link_and_storm_control_regs_tb_top;
   localparam int P100 = 20;                 // shortened period lengths
   localparam int P10  = 200;
   logic                        core_clk = 1'b0;
   logic                        rstn = 1'b0;
   logic                        flow_strap = 1'b0;
   logic                        speed_strap = 1'b0;
   logic                        reg_wr;
   logic                        reg_rd;
   logic [7:0]                  reg_addr;
   logic [7:0]                  reg_wdata;
   port4_storm_pkg::reg_byte_t  reg_rdata;
   logic                        flow_ctrl_en;
   logic                        speed_10m;
   logic                        null_vid_replace;
   port4_storm_pkg::storm_thr_t storm_threshold;
   logic                        period_tick;
   logic [3:0]                  bcast_in = 4'h0;
   logic [3:0]                  bcast_blocked;
   logic [3:0]                  mask;        // ports flooded in a storm run
   logic [31:0]                 seed = 32'h0000_2e46;
   logic [7:0]                  rv;
   logic [7:0]                  d6;
   logic [7:0]                  d7;
   int                          n_errors = 0;
   int                          samples_checked = 0;
   int                          cnt;
   logic [7:0] ofs [4] = '{`CTRL5_OFS, `TEST_A_OFS, `TEST_B_OFS, 8'h20};
   logic [7:0] ev [4]  = '{8'h4a, 8'h00, 8'h4c, 8'h00};

   always #20 core_clk = ~core_clk;

   mgmt_host HOST (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   port4_link_and_storm_control_regs #(.PERIOD_100_CYC(P100), .PERIOD_10_CYC(P10)) DUT (
      .core_clk(core_clk), .rstn(rstn), .flow_control_strap_pin(flow_strap),
      .speed_strap_pin(speed_strap), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .flow_ctrl_en(flow_ctrl_en), .speed_10m(speed_10m),
      .null_vid_replace(null_vid_replace), .storm_threshold(storm_threshold),
      .period_tick(period_tick), .bcast_block_in(bcast_in),
      .bcast_blocked(bcast_blocked));

   // xorshift source, fixed start
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   // threshold spans two registers: high three bits then low byte
   function automatic logic [10:0] exp_thr(input logic [7:0] h, input logic [7:0] l);
      return {h[2:0], l};
   endfunction : exp_thr

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim();
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   // eight cycles low, then margin past strap capture before any write
   task automatic do_reset();
      rstn = 1'b0;
      repeat (8) @(posedge core_clk);
      #1 rstn = 1'b1;
      repeat (5) @(posedge core_clk);
      #1;
   endtask : do_reset

   // bounded wait for the period pulse; cnt holds cycles waited
   task automatic wait_tick();
      cnt = 0;
      do begin
         @(posedge core_clk) #1;
         cnt++;
      end while (period_tick !== 1'b1 && cnt < 1000);
   endtask : wait_tick

   initial begin
      #(40 * 20000);
      n_errors++;
      end_sim();
   end

   initial begin
      // both strap levels, each through a full reset
      for (int s = 0; s < 2; s++) begin
         flow_strap = s[0];
         speed_strap = ~s[0];
         do_reset();
         chk(flow_ctrl_en, s[0]);
         chk(speed_10m, !s[0]);
         chk(storm_threshold, 11'h04a);
      end
      // reset values, then writes to read-only and unmapped places
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 4; i++) begin
            if (p == 1 && i > 0)
               HOST.wr(ofs[i], 8'hff);
            HOST.rd(ofs[i], rv);
            chk(rv, ev[i]);
         end
      end
      // random settings with all-ones and all-zeros corners first
      for (int k = 0; k < 12; k++) begin
         seed = xs(seed);
         d6 = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : seed[7:0];
         d7 = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : seed[15:8];
         HOST.wr(`CTRL4_OFS, d6);
         HOST.wr(`CTRL5_OFS, d7);
         chk(flow_ctrl_en, d6[5]);
         chk(speed_10m, d6[4]);
         chk(null_vid_replace, d6[3]);
         chk(storm_threshold, exp_thr(d6, d7));
         HOST.rd(`CTRL4_OFS, rv);
         chk(rv, {2'b00, d6[5:0]});
      end
      // period length per speed, then a storm of three blocks
      for (int sp = 0; sp < 2; sp++) begin
         HOST.wr(`CTRL4_OFS, sp ? 8'h10 : 8'h00);
         HOST.wr(`CTRL5_OFS, 8'h03);
         wait_tick();
         wait_tick();
         chk(cnt, sp ? P10 : P100);
         seed = xs(seed);
         mask = seed[3:0] | 4'h1;
         @(posedge core_clk) #1;
         bcast_in = mask;
         repeat (2) @(posedge core_clk) #1;
         chk(bcast_blocked, 4'h0);
         @(posedge core_clk) #1;
         bcast_in = 4'h0;
         @(posedge core_clk) #1;
         chk(bcast_blocked, mask);
         wait_tick();
         @(posedge core_clk) #1;
         chk(bcast_blocked, 4'h0);
      end
      end_sim();
   end
endmodule : port4_link_and_storm_control_regs_tb_top
